//--- umc_params.svh
// constants of the user-mode command port: window offsets, command codes,
// frame fields and reset values
// assumes inclusion by every file that decodes the window or the frames
`ifndef UMC_PARAMS_SVH
`define UMC_PARAMS_SVH

// ==================================================================
// holding register window, word offsets as seen by the master
`define UMC_REG_CMD        16'h0020
`define UMC_REG_PAD        16'h0021
`define UMC_REG_ADDR_LO    16'h0022
`define UMC_REG_ADDR_HI    16'h0023
`define UMC_REG_DATA_LO    16'h0024
`define UMC_REG_MODE       16'h0025
`define UMC_WIN_BASE_HI    13'h0004
`define UMC_WIN_WORDS      3'h6

// ==================================================================
// command codes and the parameter handled inside this block
`define UMC_CMD_WRITE      16'h0002
`define UMC_CMD_READ       16'h0003
`define UMC_MODE_ADDR      32'hF0F00624
`define UMC_MODE_MSB       15
`define UMC_MODE_LSB       12
`define UMC_MODE_RESET     4'h0

// ==================================================================
// frame fields
`define UMC_TCP_PORT       16'h01F6
`define UMC_MBAP_LEN       8'h06
`define UMC_FC_READ        8'h03
`define UMC_FC_WRITE1      8'h06
`define UMC_FC_WRITEN      8'h10
`define UMC_UNIT_MAX       8'hF7
`define UMC_QTY_MAX        16'h007D

`endif

//--- umc_pkg.sv
// types shared by the user-mode command port
// assumes umc_params.svh for the numeric constants
`default_nettype none

package umc_pkg;
    // command executor states
    typedef enum logic [0:0] {
        UMC_ST_IDLE = 1'b0,
        UMC_ST_PAR  = 1'b1
    } umc_state_t;
endpackage : umc_pkg

`default_nettype wire

//--- umc_frame_parser.sv
// frame parser: turns request bytes into holding register writes and reads
// assumes bytes arrive from logic on ref_clk, one frame between frame ends,
// with the rtu checksum already checked and stripped upstream
`include "umc_params.svh"
`default_nettype none

module umc_frame_parser
    import umc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // request bytes
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_last,
    input  wire logic        rx_rtu,
    input  wire logic [15:0] rx_port,
    input  wire logic [7:0]  unit_id_cfg,
    // decoded accesses
    output logic             wr_stb,
    output logic             wr_multi,
    output logic [15:0]      wr_addr,
    output logic [15:0]      wr_data,
    output logic             rd_stb,
    output logic             rd_last,
    output logic [15:0]      rd_addr,
    output logic             frame_done,
    output logic             frame_abort
);
    // ==================================================================
    // state
    logic [7:0]  idx_reg, idx_next, rel;
    logic        good_reg, good_next, ok;
    logic [7:0]  fc_reg, fc_next, hi_reg, hi_next;
    logic [15:0] start_reg, start_next, qty_reg, qty_next, wcnt_reg, wcnt_next;
    logic [15:0] rd_cnt_reg, rd_cnt_next, rd_ptr_reg, rd_ptr_next;
    logic        wr_stb_next, wr_multi_next, rd_stb_next, rd_last_next;
    logic        done_next, abort_next;
    logic [15:0] wr_addr_next, wr_data_next, rd_addr_next;

    // position inside the pdu, unit id first
    assign rel = idx_reg - (rx_rtu ? 8'h00 : `UMC_MBAP_LEN);

    // byte walk; a frame that breaks any check writes nothing further
    always_comb begin
        idx_next      = idx_reg;
        good_next     = good_reg;
        fc_next       = fc_reg;
        hi_next       = hi_reg;
        start_next    = start_reg;
        qty_next      = qty_reg;
        wcnt_next     = wcnt_reg;
        rd_cnt_next   = rd_cnt_reg;
        rd_ptr_next   = rd_ptr_reg;
        wr_stb_next   = 1'b0;
        wr_multi_next = wr_multi;
        wr_addr_next  = wr_addr;
        wr_data_next  = wr_data;
        rd_stb_next   = 1'b0;
        rd_last_next  = 1'b0;
        rd_addr_next  = rd_addr;
        done_next     = 1'b0;
        abort_next    = 1'b0;
        ok            = 1'b0;
        // read words go out one a cycle after the request frame
        if (rd_cnt_reg != 16'h0000) begin
            rd_stb_next  = 1'b1;
            rd_addr_next = rd_ptr_reg;
            rd_last_next = (rd_cnt_reg == 16'h0001);
            rd_ptr_next  = rd_ptr_reg + 16'h0001;
            rd_cnt_next  = rd_cnt_reg - 16'h0001;
        end
        if (rx_valid) begin
            idx_next = (idx_reg == 8'hFF) ? idx_reg : idx_reg + 8'h01;
            if (!rx_rtu && idx_reg < `UMC_MBAP_LEN) begin
                if (idx_reg == 8'h00 && rx_port != `UMC_TCP_PORT)
                    good_next = 1'b0;                              // see R6
                if ((idx_reg == 8'h02 || idx_reg == 8'h03) && rx_byte != 8'h00)
                    good_next = 1'b0;                              // see R7
            end else begin
                case (rel)
                    8'h00: begin
                        if (rx_byte != unit_id_cfg || unit_id_cfg == 8'h00 ||
                            unit_id_cfg > `UMC_UNIT_MAX)
                            good_next = 1'b0;                      // see R8
                    end
                    8'h01: begin
                        fc_next = rx_byte;
                        if (rx_byte != `UMC_FC_READ && rx_byte != `UMC_FC_WRITE1 &&
                            rx_byte != `UMC_FC_WRITEN)
                            good_next = 1'b0;
                    end
                    8'h02: start_next = {rx_byte, start_reg[7:0]};
                    8'h03: start_next = {start_reg[15:8], rx_byte};
                    8'h04: qty_next = {rx_byte, qty_reg[7:0]};
                    8'h05: begin
                        qty_next = {qty_reg[15:8], rx_byte};
                        wcnt_next = 16'h0000;
                        if (fc_reg == `UMC_FC_WRITE1 && good_reg) begin
                            wr_stb_next   = 1'b1;                  // see R13
                            wr_multi_next = 1'b0;
                            wr_addr_next  = start_reg;
                            wr_data_next  = {qty_reg[15:8], rx_byte};
                        end
                    end
                    8'h06: begin
                        if ({8'h00, rx_byte} != {qty_reg[14:0], 1'b0} ||
                            qty_reg == 16'h0000 || qty_reg > `UMC_QTY_MAX)
                            good_next = 1'b0;
                    end
                    default: begin
                        // payload words, high byte first, ascending registers
                        if (rel[0]) begin
                            hi_next = rx_byte;                     // see R10
                        end else if (good_reg && fc_reg == `UMC_FC_WRITEN &&
                                     wcnt_reg < qty_reg) begin
                            wr_stb_next   = 1'b1;                  // see R13
                            wr_multi_next = 1'b1;
                            wr_addr_next  = start_reg + wcnt_reg;
                            wr_data_next  = {hi_reg, rx_byte};
                            wcnt_next     = wcnt_reg + 16'h0001;
                        end
                    end
                endcase
            end
            if (rx_last) begin
                case (fc_reg)
                    `UMC_FC_WRITE1: ok = (rel == 8'h05);
                    `UMC_FC_READ:   ok = (rel == 8'h05) && qty_next != 16'h0000 &&
                                         qty_next <= `UMC_QTY_MAX;
                    `UMC_FC_WRITEN: ok = (wcnt_next == qty_reg) &&
                                         ({1'b0, rel} == {qty_reg[7:0], 1'b0} + 9'h006);
                    default:        ok = 1'b0;
                endcase
                ok = ok && good_next;
                done_next  = ok;
                abort_next = !ok;
                if (ok && fc_reg == `UMC_FC_READ) begin
                    rd_cnt_next = qty_next;
                    rd_ptr_next = start_reg;
                end
                idx_next  = 8'h00;
                good_next = 1'b1;
            end
        end
    end

    // registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_reg <= 8'h00;       good_reg <= 1'b1;       fc_reg <= 8'h00;
            hi_reg <= 8'h00;        start_reg <= 16'h0000;  qty_reg <= 16'h0000;
            wcnt_reg <= 16'h0000;   rd_cnt_reg <= 16'h0000; rd_ptr_reg <= 16'h0000;
            wr_stb <= 1'b0;         wr_multi <= 1'b0;       wr_addr <= 16'h0000;
            wr_data <= 16'h0000;    rd_stb <= 1'b0;         rd_last <= 1'b0;
            rd_addr <= 16'h0000;    frame_done <= 1'b0;     frame_abort <= 1'b0;
        end else begin
            idx_reg <= idx_next;    good_reg <= good_next;  fc_reg <= fc_next;
            hi_reg <= hi_next;      start_reg <= start_next; qty_reg <= qty_next;
            wcnt_reg <= wcnt_next;  rd_cnt_reg <= rd_cnt_next; rd_ptr_reg <= rd_ptr_next;
            wr_stb <= wr_stb_next;  wr_multi <= wr_multi_next; wr_addr <= wr_addr_next;
            wr_data <= wr_data_next; rd_stb <= rd_stb_next; rd_last <= rd_last_next;
            rd_addr <= rd_addr_next; frame_done <= done_next; frame_abort <= abort_next;
        end
    end

    // ==================================================================
    // checks
    AST_PID_NONZERO_DROPS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R7
        rx_valid && !rx_last && !rx_rtu && idx_reg == 8'h02 && rx_byte != 8'h00
        |=> !good_reg) else $error("nonzero protocol id kept frame alive");
    AST_WRONG_UNIT_NO_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R8
        rx_valid && !rx_last && rel == 8'h00 && idx_reg >= (rx_rtu ? 8'h00 : 8'h06)
        && rx_byte != unit_id_cfg |=> !good_reg) else $error("foreign unit id accepted");
endmodule : umc_frame_parser

`default_nettype wire

//--- umc_command_port.sv
// user-mode command port: holding register window 32..37, command trigger,
// active user mode, and the parameter port to the rest of the sensor
// assumes request bytes from a tcp or rtu front end on ref_clk and a
// parameter store that answers par_req with a one-cycle par_ack
`include "umc_params.svh"
`default_nettype none

// How it works
// R1 - a write command in register 32 writes the data of registers 37 and 36 to the address in 35 and 34.
// R2 - a read command in register 32 reads the address in 35 and 34 and returns it in 37 and 36.
// R3 - the master aims at the user mode by loading 0xF0F0 into 35, 0x0624 into 34 and zero into 33 and 36.
// R4 - register 37 carries the user mode number 0 to 15 in its top nibble with the rest zero; a mode write does not check the rest of 37.
// R5 - after a read of the user mode address, register 37 shows the active mode in that format.
// R6 - tcp requests are only taken when they arrive on port 502.
// R7 - the transaction id is free and the protocol id must be zero or the frame is dropped.
// R8 - the unit id is configurable from 1 to 247 and a frame must carry it.
// R9 - a one-frame activation is function 16 at register 0x20, six registers, 12 bytes.
// R10 - payload words come high byte first in ascending register order, 32 up to 37.
// R11 - a gateway maps its output bytes 0-1 to register 32 up to bytes 10-11 to register 37.
// R12 - the gateway can load modes only once registers 32 to 37 are mapped to its output data.
// R13 - the window is accepted both from single-register writes and from one multiple write.
// R14 - single-register writers write register 32 last.
// R15 - a write to register 32 triggers, and codes other than read and write touch nothing; the code drops a trigger that comes while busy is high.
module umc_command_port
    import umc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // request bytes from the tcp or rtu front end
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_last,
    input  wire logic        rx_rtu,
    input  wire logic [15:0] rx_port,
    input  wire logic [7:0]  unit_id_cfg,
    // read answer words
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    output logic             rsp_last,
    // parameter store
    output logic             par_req,
    output logic             par_we,
    output logic [31:0]      par_addr,
    output logic [31:0]      par_wdata,
    input  wire logic        par_ack,
    input  wire logic [31:0] par_rdata,
    // status
    output logic [3:0]       active_mode,
    output logic             busy,
    output logic             cmd_done,
    output logic             cmd_error
);
    // ==================================================================
    // reset release
    logic rst_meta, rst_n;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ==================================================================
    // frame parser
    logic        wr_stb, wr_multi, rd_stb, rd_last, frame_done, frame_abort;
    logic [15:0] wr_addr, wr_data, rd_addr;

    umc_frame_parser u_parser (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .rx_valid    (rx_valid),
        .rx_byte     (rx_byte),
        .rx_last     (rx_last),
        .rx_rtu      (rx_rtu),
        .rx_port     (rx_port),
        .unit_id_cfg (unit_id_cfg),
        .wr_stb      (wr_stb),
        .wr_multi    (wr_multi),
        .wr_addr     (wr_addr),
        .wr_data     (wr_data),
        .rd_stb      (rd_stb),
        .rd_last     (rd_last),
        .rd_addr     (rd_addr),
        .frame_done  (frame_done),
        .frame_abort (frame_abort)
    );

    // ==================================================================
    // window decode and trigger
    logic [15:0] win_reg [0:5];
    logic [15:0] win_next [0:5];
    logic        wr_hit, rd_hit, cmd_wr, go, is_mode, pend_reg, pend_next, fin_reg, fail_reg;
    logic [2:0]  wr_idx, rd_idx;
    logic [15:0] cmd_val;
    logic [31:0] tgt_addr, tgt_data;

    assign wr_idx  = wr_addr[2:0];
    assign rd_idx  = rd_addr[2:0];
    assign wr_hit  = wr_stb && wr_addr[15:3] == `UMC_WIN_BASE_HI && wr_idx < `UMC_WIN_WORDS;
    assign rd_hit  = rd_addr[15:3] == `UMC_WIN_BASE_HI && rd_idx < `UMC_WIN_WORDS;
    assign cmd_wr  = wr_stb && wr_addr == `UMC_REG_CMD;
    // a multiple write carries 32 first; it fires the cycle after the frame ends,
    // so the last word (37) has landed in the window before it is used
    assign go      = !busy && ((cmd_wr && !wr_multi) || (fin_reg && pend_reg)); // see R13
    assign cmd_val = (cmd_wr && !wr_multi) ? wr_data : win_reg[0];
    assign tgt_addr = {win_reg[3], win_reg[2]};
    assign tgt_data = {win_reg[5], win_reg[4]};
    assign is_mode  = tgt_addr == `UMC_MODE_ADDR;

    // pending trigger from a multiple write, dropped when the frame fails
    always_comb begin
        pend_next = pend_reg;
        if (fin_reg || fail_reg)
            pend_next = 1'b0;
        if (cmd_wr && wr_multi)
            pend_next = 1'b1;
    end

    // ==================================================================
    // command executor
    umc_state_t  st_reg, st_next;
    logic [3:0]  mode_next;
    logic        req_next, we_next, done_next, err_next;
    logic [31:0] paddr_next, pwdata_next;

    always_comb begin
        st_next     = st_reg;
        mode_next   = active_mode;
        req_next    = par_req;
        we_next     = par_we;
        paddr_next  = par_addr;
        pwdata_next = par_wdata;
        done_next   = 1'b0;
        err_next    = cmd_error;
        for (int i = 0; i < 6; i++)
            win_next[i] = win_reg[i];
        if (wr_hit)
            win_next[wr_idx] = wr_data;
        case (st_reg)
            UMC_ST_IDLE: begin
                if (go) begin
                    err_next = 1'b0;
                    if (cmd_val == `UMC_CMD_WRITE && is_mode) begin
                        // register 36 must be zero; the low bits of 37 are not checked, see R4
                        if (tgt_data[11:0] == 12'h000 && win_reg[4] == 16'h0000)
                            mode_next = win_reg[5][`UMC_MODE_MSB:`UMC_MODE_LSB]; // see R1
                        else
                            err_next = 1'b1;
                        done_next = 1'b1;
                    end else if (cmd_val == `UMC_CMD_READ && is_mode) begin
                        win_next[5] = {active_mode, 12'h000};      // see R5
                        win_next[4] = 16'h0000;
                        done_next   = 1'b1;
                    end else if (cmd_val == `UMC_CMD_WRITE || cmd_val == `UMC_CMD_READ) begin
                        req_next    = 1'b1;                        // see R1
                        we_next     = (cmd_val == `UMC_CMD_WRITE);
                        paddr_next  = tgt_addr;                    // see R2
                        pwdata_next = tgt_data;
                        st_next     = UMC_ST_PAR;
                    end else begin
                        err_next = 1'b1;                           // see R15
                    end
                end
            end
            UMC_ST_PAR: begin
                // the store result wins over a master write landing the same cycle
                if (par_ack) begin
                    req_next  = 1'b0;
                    done_next = 1'b1;
                    st_next   = UMC_ST_IDLE;
                    if (!par_we) begin
                        win_next[5] = par_rdata[31:16];            // see R2
                        win_next[4] = par_rdata[15:0];
                    end
                end
            end
            default: st_next = UMC_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg      <= UMC_ST_IDLE;
            pend_reg    <= 1'b0;
            fin_reg     <= 1'b0;
            fail_reg    <= 1'b0;
            active_mode <= `UMC_MODE_RESET;
            par_req     <= 1'b0;
            par_we      <= 1'b0;
            par_addr    <= 32'h00000000;
            par_wdata   <= 32'h00000000;
            busy        <= 1'b0;
            cmd_done    <= 1'b0;
            cmd_error   <= 1'b0;
            for (int i = 0; i < 6; i++)
                win_reg[i] <= 16'h0000;
        end else begin
            st_reg      <= st_next;
            pend_reg    <= pend_next;
            fin_reg     <= frame_done;
            fail_reg    <= frame_abort;
            active_mode <= mode_next;
            par_req     <= req_next;
            par_we      <= we_next;
            par_addr    <= paddr_next;
            par_wdata   <= pwdata_next;
            busy        <= (st_next == UMC_ST_PAR);
            cmd_done    <= done_next;
            cmd_error   <= err_next;
            for (int i = 0; i < 6; i++)
                win_reg[i] <= win_next[i];
        end
    end

    // ==================================================================
    // read answers; outside the window reads as zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_data  <= 16'h0000;
            rsp_last  <= 1'b0;
        end else begin
            rsp_valid <= rd_stb;
            rsp_data  <= (rd_stb && rd_hit) ? win_reg[rd_idx] : 16'h0000;
            rsp_last  <= rd_stb && rd_last;
        end
    end

    // ==================================================================
    // checks
    AST_MODE_WRITE_LOADS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R1
        go && cmd_val == `UMC_CMD_WRITE && is_mode && tgt_data[11:0] == 12'h000
        && win_reg[4] == 16'h0000 |=> active_mode == $past(win_reg[5][15:12]) && cmd_done)
        else $error("mode write did not load the mode");
    AST_MODE_READ_FORMAT: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R5
        go && cmd_val == `UMC_CMD_READ && is_mode
        |=> win_reg[5] == {active_mode, 12'h000} && win_reg[4] == 16'h0000)
        else $error("mode read returned a wrong word");
    AST_BAD_LOW_BITS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R4
        go && cmd_val == `UMC_CMD_WRITE && is_mode && tgt_data[11:0] != 12'h000
        |=> cmd_error && $stable(active_mode)) else $error("malformed mode word taken");
    AST_OTHER_CODE_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R15
        go && cmd_val != `UMC_CMD_WRITE && cmd_val != `UMC_CMD_READ
        |=> !par_req && $stable(active_mode) && cmd_error) else $error("stray code acted");
    AST_PAR_ISSUE: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R2
        go && cmd_val == `UMC_CMD_READ && !is_mode
        |=> par_req && !par_we && par_addr == $past(tgt_addr)) else $error("read not issued");
    AST_PAR_HELD: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R1
        par_req && !par_ack |=> par_req && $stable(par_addr) && $stable(par_wdata))
        else $error("parameter request dropped early");
    AST_MULTI_DEFERS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R13
        cmd_wr && wr_multi |-> !go ##1 pend_reg) else $error("multiple write fired early");
    AST_SINGLE_FIRES: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R15
        cmd_wr && !wr_multi && !busy |-> go) else $error("register 32 write did not trigger");
    AST_READ_ANSWER: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R10
        rd_stb && rd_addr == `UMC_REG_MODE |=> rsp_valid && rsp_data == $past(win_reg[5]))
        else $error("read answer wrong");

    COV_MODE_WRITE: cover property (@(posedge ref_clk) disable iff (!rst_n)
        fin_reg && pend_reg && is_mode ##1 cmd_done);
    COV_MODE_READ: cover property (@(posedge ref_clk) disable iff (!rst_n)
        go && cmd_val == `UMC_CMD_READ && is_mode);
    COV_PAR_CYCLE: cover property (@(posedge ref_clk) disable iff (!rst_n)
        par_req ##[1:20] par_ack);
    COV_ABORT: cover property (@(posedge ref_clk) disable iff (!rst_n)
        pend_reg && frame_abort);
endmodule : umc_command_port

`default_nettype wire

//--- umc_store_model.sv
// parameter store model: answers each par_req with a one-cycle par_ack
// assumes ref_clk and resetn of the command port
`default_nettype none
module umc_store_model (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // store port
    input  wire logic        par_req,
    input  wire logic [31:0] par_addr,
    output var  logic        par_ack,
    output var  logic [31:0] par_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    int          cnt;
    logic [31:0] tick;
    // ==========
    // random wait of 1..4 cycles; rdata moves outside the ack cycle
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            par_ack <= 0;
            cnt     <= 0;
            tick    <= 0;
        end else begin
            tick      <= tick + 1;
            par_ack   <= 0;
            par_rdata <= tick ^ 32'h5A5A0000;
            if (par_req && !par_ack) begin
                if (cnt == 0) cnt <= 1 + $urandom % 4;
                else if (cnt > 1) cnt <= cnt - 1;
                else begin
                    cnt       <= 0;
                    par_ack   <= 1;
                    par_rdata <= ~par_addr;
                end
            end
        end
    end
endmodule : umc_store_model
`default_nettype wire

//--- umc_command_port_bench.sv
// bench of the command port: frames in, store model on the far side
// assumes one 125 MHz clock and the store model beside the port
`default_nettype none
module umc_command_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, resetn = 0, rx_valid = 0, rx_last = 0, rx_rtu = 0;
    logic [7:0] rx_byte = 0, unit_id_cfg = 8'h01;
    logic [15:0] rx_port = 0, rsp_data, rq[$];
    logic rsp_valid, rsp_last, par_req, par_we, par_ack, busy, cmd_done, cmd_error, pwe, rl;
    logic [31:0] par_addr, par_wdata, par_rdata, pa, pw, ea, ew;
    logic [3:0] active_mode;
    logic [7:0] q[$];
    int bad_count = 0, check_count = 0, nreq = 0, m;
    umc_command_port u_umc_command_port (.ref_clk, .resetn, .rx_valid, .rx_byte, .rx_last,
        .rx_rtu, .rx_port, .unit_id_cfg, .rsp_valid, .rsp_data, .rsp_last, .par_req, .par_we,
        .par_addr, .par_wdata, .par_ack, .par_rdata, .active_mode, .busy, .cmd_done, .cmd_error);
    umc_store_model u_umc_store_model (.ref_clk, .resetn, .par_req, .par_addr, .par_ack,
        .par_rdata);
    always #4 ref_clk = ~ref_clk;
    // store requests as they stand, sampled away from the edge
    always @(posedge par_req) nreq++;
    always @(negedge ref_clk) if (par_req === 1'b1) {pwe, pa, pw} = {par_we, par_addr, par_wdata};
    always @(negedge ref_clk) if (rsp_valid === 1'b1) begin
        rq.push_back(rsp_data);
        rl = rsp_last;
    end
    task automatic chk(input string n, input logic [64:0] e, input logic [64:0] s);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic end_of_test;
        if (bad_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    // one byte a cycle, rx_last with the final byte
    task automatic tx(input logic rtu, input logic [15:0] port);
        foreach (q[i]) begin
            @(posedge ref_clk) {rx_rtu, rx_port, rx_valid, rx_byte} <= {rtu, port, 1'b1, q[i]};
            rx_last <= (i == q.size() - 1);
        end
        @(posedge ref_clk) {rx_valid, rx_last} <= 2'b00;
        for (int k = 0; k < 40 && cmd_done !== 1'b1; k++) @(negedge ref_clk);
    endtask : tx
    task automatic fr(input logic [15:0] port, pid, c, ah, al, dh, dl);
        q = {8'hF4, 8'h06, pid[15:8], pid[7:0], 8'h00, 8'h13, 8'h01, 8'h10, 8'h00, 8'h20, 8'h00,
             8'h06, 8'h0C, c[15:8], c[7:0], 8'h00, 8'h00, al[15:8], al[7:0], ah[15:8], ah[7:0],
             dl[15:8], dl[7:0], dh[15:8], dh[7:0]};
        tx(0, port);
    endtask : fr
    task automatic s6(input logic [7:0] r, input logic [15:0] v);
        q = {8'h01, 8'h06, 8'h00, r, v[15:8], v[7:0]};
        tx(1, 0);
    endtask : s6
    task automatic rd(input logic [7:0] a, input int n);
        q = {8'h01, 8'h03, 8'h00, a, 8'h00, n[7:0]};
        rq = {};
        tx(1, 0);
        chk("answer words", n * 2 + 1, rq.size() * 2 + rl);
    endtask : rd
    initial begin
        void'($urandom(32'h866B));
        repeat (12) @(posedge ref_clk);
        resetn <= 1;
        repeat (4) @(posedge ref_clk);
        m = $urandom % 16;
        fr(16'h01F6, 0, 16'h0002, 16'hF0F0, 16'h0624, m << 12, 0);
        chk("tcp mode", m, active_mode);
        // wrong port, nonzero protocol id, foreign unit id: all dropped
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk) unit_id_cfg <= (k == 2) ? 8'h05 : 8'h01;
            fr(k == 0 ? 16'h01F7 : 16'h01F6, k == 1, 16'h0002, 16'hF0F0, 16'h0624, ~m << 12, 0);
            chk("dropped", m, active_mode);
        end
        @(posedge ref_clk) unit_id_cfg <= 8'h01;
        m = $urandom % 16;
        s6(8'h25, m << 12);
        s6(8'h24, 0);
        s6(8'h23, 16'hF0F0);
        s6(8'h22, 16'h0624);
        s6(8'h21, 0);
        s6(8'h20, 16'h0002);
        chk("single mode", m, active_mode);
        s6(8'h25, 16'h0FFF);
        s6(8'h20, 16'h0003);
        rd(8'h25, 1);
        chk("mode word", m << 12, rq[0]);
        nreq = 0;
        fr(16'h01F6, 0, 16'h0007, 16'hF0F0, 16'h0624, 0, 0);
        chk("no access", 2'b10, {cmd_error, nreq != 0});
        {ea, ew} = {$urandom, $urandom};
        fr(16'h01F6, 0, 16'h0002, ea[31:16], ea[15:0], ew[31:16], ew[15:0]);
        chk("store write", {1'b1, ea, ew}, {pwe, pa, pw});
        fr(16'h01F6, 0, 16'h0003, ea[31:16], ea[15:0], 0, 0);
        rd(8'h24, 2);
        chk("store read", {1'b0, ea, ~ea}, {pwe, pa, rq[1], rq[0]});
        end_of_test;
    end
    // cut a hang short well beyond the expected run
    initial begin
        #200000;
        bad_count++;
        end_of_test;
    end
endmodule : umc_command_port_bench
`default_nettype wire
